/* pcim_consts.vh */
`ifndef PCIM_CONSTS_VH
`define PCIM_CONSTS_VH
// port 4 pin positions used by the mux
`define PCIM_PIN_SCL      0
`define PCIM_PIN_CANB_RX  0
`define PCIM_PIN_CANA_RX  1
`define PCIM_PIN_CANA_TX  2
`define PCIM_PIN_CANB_TX  3
// upper-nibble segment lines available without and with can in use
`define PCIM_SEG_FULL     4'h8
`define PCIM_SEG_CAN      4'h4
// reset values of enable bits
`define PCIM_RST_CAN_A    1'b1
`define PCIM_RST_CAN_B    1'b0
`define PCIM_RST_I2C      1'b0
`define PCIM_RST_MISC     1'b0
`define PCIM_RST_SHARE    1'b0
`define PCIM_RST_GLOBAL   1'b0
// can unit select address bit
`define PCIM_CAN_SEL_BIT  8
`endif

/* pcim_port4_mux.v */
// Summary of operation
// - i2c enable puts scl/sda open-drain on pins
// - port registers ignored on i2c pins
// - i2c off restores ordinary port pins
// - can a tx on bit6, rx bit5
// - can b tx bit7, rx bit4 unshared
// - reset: can a on, can b off
// - can units split by address bit 8
// - can in use limits segment lines four
// - can transmit honours open-drain register
// - sharing bit routes both cans to 5/6
// - misc register needs both enables set
// - can interrupts merged onto shared lines
// - freed pins never external address lines
`timescale 1ns/10ps
`include "pcim_consts.vh"
module pcim_port4_mux #(
  parameter NVEC = 4
) (
  input  wire            clk_in,
  input  wire            rstn_in,
  input  wire            can_a_en_wr_in,
  input  wire            can_b_en_wr_in,
  input  wire            i2c_en_wr_in,
  input  wire            misc_en_wr_in,
  input  wire            en_wr_strobe_in,
  input  wire            global_en_wr_in,
  input  wire            global_wr_strobe_in,
  input  wire            share_wr_in,
  input  wire            misc_wr_strobe_in,
  input  wire [3:0]      port4_data_reg_in,
  input  wire [3:0]      port4_direction_reg_in,
  input  wire [3:0]      port4_open_drain_reg_in,
  input  wire [3:0]      seg_addr_in,
  input  wire [3:0]      seg_addr_sel_in,
  input  wire [3:0]      pin_in,
  input  wire            can_a_transmit_in,
  input  wire            can_b_transmit_in,
  input  wire            scl_drive_low_in,
  input  wire            sda_drive_low_in,
  input  wire            can_a_irq_in,
  input  wire            can_b_irq_in,
  input  wire [NVEC-1:0] other_irq_in,
  input  wire [NVEC-1:0] can_a_irq_vec_in,
  input  wire [NVEC-1:0] can_b_irq_vec_in,
  input  wire [9:0]      can_addr_in,
  input  wire            can_access_in,
  output reg  [3:0]      pin_out,
  output reg  [3:0]      pin_oen_out,
  output reg  [3:0]      port_pin_read_out,
  output reg             can_a_receive_out,
  output reg             can_b_receive_out,
  output reg             scl_in_out,
  output reg             sda_in_out,
  output wire            can_a_sel_out,
  output wire            can_b_sel_out,
  output wire [7:0]      can_reg_offset_out,
  output reg  [NVEC-1:0] periph_irq_out,
  output wire            can_a_enabled_out,
  output wire            can_b_enabled_out,
  output wire            i2c_enabled_out,
  output wire            share_active_out,
  output wire            misc_access_ok_out,
  output wire [3:0]      seg_lines_avail_out
);
  reg       can_a_en_reg;
  reg       can_b_en_reg;
  reg       i2c_enable_bit_reg;
  reg       misc_en_reg;
  reg       global_en_reg;
  reg       share_reg;
  reg [3:0] pin_meta_reg;
  reg [3:0] pin_sync_reg;
  reg [3:0] pout_next;
  reg [3:0] poen_next;
  reg [NVEC-1:0] irq_next;
  wire      misc_ok;
  wire      can_on;
  wire      seg_allowed;
  wire      shared_tx;
  wire [3:0] gp_out;
  wire [3:0] gp_oen;
  wire [NVEC-1:0] can_a_irq_w;
  wire [NVEC-1:0] can_b_irq_w;
  genvar    g;

  // an open-drain bit at 1 floats, so the pull-up or a peer decides
  function odr_oen;
    input od_bit;
    input val_bit;
    begin
      odr_oen = od_bit & val_bit;
    end
  endfunction

  // misc access gated
  // misc register gating
  assign misc_ok = misc_en_reg & global_en_reg;
  assign can_on  = can_a_en_reg | can_b_en_reg;

  assign seg_allowed = ~can_on;

  // wired-and: a disabled unit sits recessive
  assign shared_tx = (can_a_transmit_in | ~can_a_en_reg) &
                     (can_b_transmit_in | ~can_b_en_reg);

  assign can_a_irq_w = {NVEC{can_a_irq_in & can_a_en_reg}} & can_a_irq_vec_in;
  assign can_b_irq_w = {NVEC{can_b_irq_in & can_b_en_reg}} & can_b_irq_vec_in;

  // ordinary port bits, segment address only without can
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_port
      assign gp_out[g] = (seg_addr_sel_in[g] && seg_allowed) ?
                         seg_addr_in[g] :
                         (port4_direction_reg_in[g] & port4_data_reg_in[g]);
      assign gp_oen[g] = (seg_addr_sel_in[g] && seg_allowed) ? 1'b0 :
                         (port4_direction_reg_in[g] ?
                          odr_oen(port4_open_drain_reg_in[g],
                                  port4_data_reg_in[g]) : 1'b1);
    end
  endgenerate

  // two flops: pin_in is asynchronous to clk_in
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      can_a_en_reg       <= `PCIM_RST_CAN_A;
      can_b_en_reg       <= `PCIM_RST_CAN_B;
      i2c_enable_bit_reg <= `PCIM_RST_I2C;
      misc_en_reg        <= `PCIM_RST_MISC;
      global_en_reg      <= `PCIM_RST_GLOBAL;
      share_reg          <= `PCIM_RST_SHARE;
      pin_out            <= 4'h0;
      pin_oen_out        <= 4'hf;
      periph_irq_out     <= {NVEC{1'b0}};
    end else begin
      // can and misc enables held while global on, i2c enable loads any time
      if (en_wr_strobe_in && !global_en_reg) begin
        can_a_en_reg       <= can_a_en_wr_in;
        can_b_en_reg       <= can_b_en_wr_in;
        misc_en_reg        <= misc_en_wr_in;
      end
      if (en_wr_strobe_in)
        i2c_enable_bit_reg <= i2c_en_wr_in;
      if (global_wr_strobe_in)
        global_en_reg <= global_en_wr_in;
      if (misc_wr_strobe_in && misc_ok)
        share_reg <= share_wr_in;
      pin_out        <= pout_next;
      pin_oen_out    <= poen_next;
      periph_irq_out <= irq_next;
    end
  end

  always @* begin
    pout_next = gp_out;
    poen_next = gp_oen;

    // can a transmit pin, open-drain honoured
    if (can_a_en_reg || (share_reg && can_b_en_reg)) begin
      pout_next[`PCIM_PIN_CANA_TX] = share_reg ? shared_tx : can_a_transmit_in;
      poen_next[`PCIM_PIN_CANA_TX] =
        odr_oen(port4_open_drain_reg_in[`PCIM_PIN_CANA_TX],
                pout_next[`PCIM_PIN_CANA_TX]);
    end

    // can b transmit pin unshared, i2c wins on conflict
    if (can_b_en_reg && !share_reg) begin
      pout_next[`PCIM_PIN_CANB_TX] = can_b_transmit_in;
      poen_next[`PCIM_PIN_CANB_TX] =
        odr_oen(port4_open_drain_reg_in[`PCIM_PIN_CANB_TX], can_b_transmit_in);
    end

    // open-drain i2c pins, port registers ignored
    if (i2c_enable_bit_reg) begin
      pout_next[`PCIM_PIN_CANB_RX] = 1'b0;
      poen_next[`PCIM_PIN_CANB_RX] = ~scl_drive_low_in;
      pout_next[`PCIM_PIN_CANB_TX] = 1'b0;
      poen_next[`PCIM_PIN_CANB_TX] = ~sda_drive_low_in;
    end

    // merge can interrupts onto shared vectors
    irq_next = other_irq_in | can_a_irq_w | can_b_irq_w;
  end

  always @* begin
    port_pin_read_out = pin_sync_reg;
    can_a_receive_out = pin_sync_reg[`PCIM_PIN_CANA_RX];
    can_b_receive_out = share_reg ? pin_sync_reg[`PCIM_PIN_CANA_RX]
                                  : pin_sync_reg[`PCIM_PIN_CANB_RX];
    scl_in_out = i2c_enable_bit_reg ? pin_sync_reg[`PCIM_PIN_CANB_RX] : 1'b1;
    sda_in_out = i2c_enable_bit_reg ? pin_sync_reg[`PCIM_PIN_CANB_TX] : 1'b1;
  end

  // chip select by address bit 8
  assign can_a_sel_out = can_access_in & ~can_addr_in[`PCIM_CAN_SEL_BIT]
                         & can_a_en_reg & global_en_reg;
  assign can_b_sel_out = can_access_in & can_addr_in[`PCIM_CAN_SEL_BIT]
                         & can_b_en_reg & global_en_reg;
  assign can_reg_offset_out = can_addr_in[7:0];
  assign can_a_enabled_out  = can_a_en_reg;
  assign can_b_enabled_out  = can_b_en_reg;
  assign i2c_enabled_out    = i2c_enable_bit_reg;
  assign share_active_out   = share_reg;
  assign misc_access_ok_out = misc_ok;
  assign seg_lines_avail_out = can_on ? `PCIM_SEG_CAN : `PCIM_SEG_FULL;
endmodule // pcim_port4_mux

/* pcim_bus_model.sv */
`timescale 1ns/10ps
module pcim_bus_model (
  input  wire [3:0] drv_in,
  input  wire [3:0] oen_in,
  input  wire [3:0] ext_low_in,
  output wire [3:0] wire_out
);
  // pull-ups: a released line reads high, any party may pull it low
  assign wire_out = ~ext_low_in & (drv_in | oen_in);
endmodule // pcim_bus_model

/* pcim_chk.sv */
`timescale 1ns/10ps
module pcim_chk (
  input wire       clk_in, rstn_in, scl_drive_low_in, sda_drive_low_in,
  input wire       can_a_transmit_in, can_b_transmit_in,
  input wire [3:0] port4_open_drain_reg_in, pin_out, pin_oen_out,
  input wire [9:0] can_addr_in,
  input wire       can_a_sel_out, can_b_sel_out, i2c_enabled_out,
  input wire       can_a_enabled_out, can_b_enabled_out, share_active_out,
  input wire [3:0] seg_lines_avail_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  reset_state_a: assert property ($rose(rstn_in) |->
    can_a_enabled_out && !can_b_enabled_out) else $error("reset enables");
  i2c_pins_a: assert property (i2c_enabled_out |=>
    pin_oen_out[0] == !$past(scl_drive_low_in) &&
    pin_oen_out[3] == !$past(sda_drive_low_in)) else $error("i2c pins");
  can_a_tx_a: assert property (can_a_enabled_out && !can_a_transmit_in
    |=> !pin_oen_out[2] && !pin_out[2]) else $error("can a tx");
  tx_open_a: assert property (can_a_enabled_out && !can_b_enabled_out &&
    can_a_transmit_in && port4_open_drain_reg_in[2] |=> pin_oen_out[2])
    else $error("tx open drain");
  can_b_tx_a: assert property (can_b_enabled_out && !share_active_out &&
    !i2c_enabled_out && !port4_open_drain_reg_in[3] |=>
    pin_out[3] == $past(can_b_transmit_in) && !pin_oen_out[3])
    else $error("can b tx");
  cs_split_a: assert property (can_a_sel_out || can_b_sel_out |->
    can_b_sel_out == can_addr_in[8] && can_a_sel_out != can_b_sel_out)
    else $error("chip select");
  seg_lines_a: assert property (seg_lines_avail_out ==
    ((can_a_enabled_out || can_b_enabled_out) ? 4'h4 : 4'h8))
    else $error("segment lines");
endmodule // pcim_chk
bind pcim_port4_mux pcim_chk u_chk (.*);

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk_in = 0, rstn_in = 0, can_a_en_wr_in = 0, can_b_en_wr_in = 0;
  logic i2c_en_wr_in = 0, misc_en_wr_in = 0, en_wr_strobe_in = 0;
  logic global_en_wr_in = 0, global_wr_strobe_in = 0, share_wr_in = 0;
  logic misc_wr_strobe_in = 0, can_a_transmit_in = 1, can_b_transmit_in = 1;
  logic scl_drive_low_in = 0, sda_drive_low_in = 0, can_access_in = 0;
  logic can_a_irq_in = 0, can_b_irq_in = 0;
  logic [3:0] port4_data_reg_in = 4'h0, port4_direction_reg_in = 4'h0;
  logic [3:0] port4_open_drain_reg_in = 4'h0, seg_addr_in = 4'h0;
  logic [3:0] seg_addr_sel_in = 4'h0, other_irq_in = 4'h0, ext_low = 4'h0;
  logic [3:0] can_a_irq_vec_in = 4'h0, can_b_irq_vec_in = 4'h0;
  logic [9:0] can_addr_in = 10'h000;
  wire  [3:0] pin_in, pin_out, pin_oen_out, port_pin_read_out;
  wire  [3:0] periph_irq_out, seg_lines_avail_out;
  wire  [7:0] can_reg_offset_out;
  wire can_a_receive_out, can_b_receive_out, scl_in_out, sda_in_out;
  wire can_a_sel_out, can_b_sel_out, can_a_enabled_out, can_b_enabled_out;
  wire i2c_enabled_out, share_active_out, misc_access_ok_out;
  int err_count = 0, cmp_count = 0, cyc = 0;
  pcim_port4_mux u_dut (.*);
  pcim_bus_model u_bus (.drv_in(pin_out), .oen_in(pin_oen_out),
    .ext_low_in(ext_low), .wire_out(pin_in));
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input string what, input logic [9:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // can and misc enables load only while global is off (i2c enable loads any time), so order matters to software
  task automatic wr_en(input logic a, b, i);
    @(negedge clk_in);
    {can_a_en_wr_in, can_b_en_wr_in, i2c_en_wr_in} = {a, b, i};
    en_wr_strobe_in = 1;
    w(1);
    en_wr_strobe_in = 0;
    w(2);
  endtask
  task automatic t_can();
    can_a_transmit_in = 0;
    w(2);
    chk("tx a", 0, {pin_out[2], pin_oen_out[2]});
    {can_a_transmit_in, port4_open_drain_reg_in, ext_low} = {1'b1, 8'h42};
    w(4);
    chk("tx a od", 1, pin_oen_out[2]);
    chk("rx a", 0, can_a_receive_out);
    {port4_open_drain_reg_in, ext_low} = 8'h01;
    wr_en(1, 1, 0);
    can_b_transmit_in = 0;
    w(3);
    chk("tx b", 0, {pin_out[3], pin_oen_out[3]});
    chk("rx b", 0, can_b_receive_out);
    {can_b_transmit_in, ext_low} = 5'h10;
    wr_en(1, 0, 0);
  endtask
  task automatic t_i2c();
    port4_direction_reg_in = 4'hf;
    wr_en(1, 0, 1);
    chk("i2c released", 4'h9, pin_oen_out & 4'h9);
    ext_low = 4'h1;
    w(3);
    chk("scl in", 0, scl_in_out);
    {ext_low, scl_drive_low_in} = 5'h01;
    w(2);
    chk("scl low", 3'b100, {pin_oen_out[3], pin_oen_out[0], pin_out[0]});
    chk("sda in", 1, sda_in_out);
    {scl_drive_low_in, port4_data_reg_in} = 5'h08;
    wr_en(1, 0, 0);
    chk("port", 4'h4, {pin_oen_out[3], pin_out[3], pin_oen_out[0], pin_out[0]});
  endtask
  task automatic t_sel_irq();
    wr_en(1, 1, 0);
    {can_access_in, can_addr_in} = 11'h505;
    w(1);
    chk("sel off", 0, can_b_sel_out);
    {global_en_wr_in, global_wr_strobe_in} = 2'b11;
    w(1);
    global_wr_strobe_in = 0;
    w(1);
    chk("sel b", 10'h105, {can_a_sel_out, can_b_sel_out, can_reg_offset_out});
    can_addr_in = 10'h005;
    w(1);
    chk("sel a", 10'h205, {can_a_sel_out, can_b_sel_out, can_reg_offset_out});
    wr_en(1, 0, 0);
    chk("b locked", 1, can_b_enabled_out);
    {can_a_irq_in, can_b_irq_in, can_a_irq_vec_in, can_b_irq_vec_in} = 10'h328;
    other_irq_in = 4'h1;
    w(2);
    chk("irq", 4'hb, periph_irq_out);
  endtask
  task automatic t_share();
    {global_en_wr_in, global_wr_strobe_in} = 2'b01;
    w(1);
    {share_wr_in, misc_wr_strobe_in, global_wr_strobe_in} = 3'b110;
    w(1);
    misc_wr_strobe_in = 0;
    w(1);
    chk("misc gate", 0, {misc_access_ok_out, share_active_out});
    misc_en_wr_in = 1;
    wr_en(1, 1, 0);
    {global_en_wr_in, global_wr_strobe_in} = 2'b11;
    w(1);
    {misc_wr_strobe_in, global_wr_strobe_in} = 2'b10;
    w(1);
    misc_wr_strobe_in = 0;
    {can_b_transmit_in, ext_low, port4_data_reg_in} = 9'h029;
    w(3);
    chk("misc share", 2'b11, {misc_access_ok_out, share_active_out});
    chk("tx shared", 0, {pin_out[2], pin_oen_out[2]});
    chk("pin7 free", 2'b10, {pin_out[3], pin_oen_out[3]});
    chk("rx b shared", 0, can_b_receive_out);
    chk("pin read", 4'h9, port_pin_read_out);
    {can_b_transmit_in, ext_low} = 5'h10;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    w(3);
    rstn_in = 1;
    w(1);
    chk("reset", 10'h024,
        {can_a_enabled_out, can_b_enabled_out, seg_lines_avail_out});
    t_can();
    t_i2c();
    t_sel_irq();
    t_share();
    report_and_stop();
  end
endmodule // testbench
